//--- logic/rtc_calendar.sv
// Purpose: Calendar mode of the timer: second tick, BCD time counters, periodic requests, clock out.
// Assumes: One clock, register port with read data one cycle after the read strobe.
// Notes:   Request output is a one-cycle pulse for an outside interrupt controller.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_calendar #(
   parameter int ADDR_W = `RTC_ADDR_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic subclk_edge_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   output logic timer_output_pin_o,
   output logic timer_output_oe_o,
   output logic periodic_irq_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   rtc_pkg::ctrl1_s ctrl1_r;
   logic [6:0] csrc_r;
   logic [4:0] ctrl2_r;
   logic [1:0] adj_r;
   logic [7:0] sec_r;
   logic [7:0] min_r;
   logic [7:0] hr_r;
   logic [2:0] wk_r;
   logic div2_r;
   logic [3:0] cnt4_r;
   logic [7:0] cnt8_r;
   rtc_pkg::clk_taps_s taps;
   logic slow_en;

   rtc_divider u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .subclk_edge_i(subclk_edge_i),
      .taps_o(taps),
      .slow_en_o(slow_en)
   );

   // Returns {wrap, next} for a BCD count that runs 00..top
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
      logic [8:0] r;
      if (v == top)
         r = 9'h100;
      else if (v[3:0] == 4'h9)
         r = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         r = {1'b0, v + 8'h01};
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Register port decode
   // ---------------------------------------------------------------
   wire wr_c1 = we_i && (addr_i == ADDR_W'(`OFF_CTRL1));
   wire wr_c2 = we_i && (addr_i == ADDR_W'(`OFF_CTRL2));
   wire wr_cs = we_i && (addr_i == ADDR_W'(`OFF_CSRC));
   wire wr_adj = we_i && (addr_i == ADDR_W'(`OFF_ADJUST));
   wire time_wr_ok = !ctrl1_r.run_control && !ctrl1_r.count_status_flag;
   wire wr_sec = we_i && time_wr_ok && (addr_i == ADDR_W'(`OFF_SECONDS));
   wire wr_min = we_i && time_wr_ok && (addr_i == ADDR_W'(`OFF_MINUTES));
   wire wr_hr = we_i && time_wr_ok && (addr_i == ADDR_W'(`OFF_HOURS));
   wire wr_wk = we_i && time_wr_ok && (addr_i == ADDR_W'(`OFF_WEEKDAY));
   rtc_pkg::ctrl1_s c1_wr;
   assign c1_wr = rtc_pkg::ctrl1_s'(wdata_i);
   // The reset acts on the write that drops the bit after it was set
   wire soft_rst = wr_c1 && ctrl1_r.soft_timer_reset && !wdata_i[`C1_SRST];
   wire adj_inc = wr_adj && wdata_i[`ADJ_INC] && !wdata_i[`ADJ_DEC];
   wire adj_dec = wr_adj && wdata_i[`ADJ_DEC] && !wdata_i[`ADJ_INC];

   // ---------------------------------------------------------------
   // Prescale chain and time carries
   // ---------------------------------------------------------------
   wire count_en = ctrl1_r.count_status_flag && slow_en;
   wire cnt4_step = count_en && div2_r;
   wire cnt8_step = cnt4_step && (cnt4_r == `CNT4_TOP);
   wire sec_tick = cnt8_step && (cnt8_r == `CNT8_TOP);
   wire [7:0] hr_top = ctrl1_r.hour_format_select ? `HR24_MAX : `HR12_MAX;
   wire [8:0] sec_w = bcd_inc(sec_r, `SEC_MAX);
   wire [8:0] min_w = bcd_inc(min_r, `MIN_MAX);
   wire [8:0] hr_w = bcd_inc(hr_r, hr_top);
   wire min_upd = sec_tick && sec_w[8];
   wire hr_upd = min_upd && min_w[8];
   wire hr_wrap = hr_upd && hr_w[8];
   wire mer_flip = hr_wrap && !ctrl1_r.hour_format_select;
   // In 12-hour format the day ends only when the afternoon wraps; 24-hour ignores the flag
   wire day_upd = hr_wrap && (ctrl1_r.hour_format_select || ctrl1_r.meridiem_flag);
   wire [2:0] wk_next = (wk_r == `WK_MAX) ? 3'h0 : wk_r + 3'h1;
   wire week_evt = day_upd && (wk_r == `WK_MAX);
   wire irq_nxt = (ctrl2_r[`IE_SEC] && sec_tick) || (ctrl2_r[`IE_MIN] && min_upd) ||
                  (ctrl2_r[`IE_HOUR] && hr_upd) || (ctrl2_r[`IE_DAY] && day_upd) ||
                  (ctrl2_r[`IE_WEEK] && week_evt);

   // ---------------------------------------------------------------
   // Clock output select
   // ---------------------------------------------------------------
   wire [2:0] osel = csrc_r[6:4];
   wire osel_clk = (osel == rtc_pkg::OSEL_F2) ? taps.f2 :
                   (osel == rtc_pkg::OSEL_FC) ? taps.fc :
                   (osel == rtc_pkg::OSEL_F4) ? taps.f4 :
                   (osel == rtc_pkg::OSEL_1HZ) ? cnt8_r[`HZ_BIT] :
                   (osel == rtc_pkg::OSEL_F8) ? taps.f8 : 1'b0;
   wire pin_nxt = ctrl1_r.clock_out_enable && osel_clk;

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   wire [7:0] rd_mux =
      (addr_i == ADDR_W'(`OFF_SECONDS)) ? sec_r :
      (addr_i == ADDR_W'(`OFF_MINUTES)) ? min_r :
      (addr_i == ADDR_W'(`OFF_HOURS)) ? hr_r :
      (addr_i == ADDR_W'(`OFF_WEEKDAY)) ? {5'h00, wk_r} :
      (addr_i == ADDR_W'(`OFF_CTRL1)) ? (ctrl1_r & `C1_RD_MASK) :
      (addr_i == ADDR_W'(`OFF_CTRL2)) ? {3'h0, ctrl2_r} :
      (addr_i == ADDR_W'(`OFF_CSRC)) ? {1'b0, csrc_r} :
      (addr_i == ADDR_W'(`OFF_ADJUST)) ? {6'h00, adj_r} : 8'h00;

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl1_r <= rtc_pkg::ctrl1_s'(`C1_RESET);
         csrc_r <= 7'(`CSRC_RESET);
         adj_r <= 2'h0;
      end else begin
         if (wr_c1) begin
            ctrl1_r.run_control <= c1_wr.run_control && !soft_rst;
            ctrl1_r.hour_format_select <= c1_wr.hour_format_select && !soft_rst;
            ctrl1_r.meridiem_flag <= c1_wr.meridiem_flag && !soft_rst;
            ctrl1_r.soft_timer_reset <= c1_wr.soft_timer_reset;
            ctrl1_r.irq_timing <= c1_wr.irq_timing && !soft_rst;
            ctrl1_r.clock_out_enable <= c1_wr.clock_out_enable;
         end else if (mer_flip) begin
            ctrl1_r.meridiem_flag <= ~ctrl1_r.meridiem_flag;
         end
         // Status follows the run bit at the count source rate
         if (soft_rst)
            ctrl1_r.count_status_flag <= 1'b0;
         else if (slow_en)
            ctrl1_r.count_status_flag <= ctrl1_r.run_control;
         if (wr_cs)
            csrc_r <= wdata_i[6:0];
         if (wr_adj)
            adj_r <= wdata_i[1:0];
      end
   end

   // ---------------------------------------------------------------
   // Prescale counters
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div2_r <= 1'b0;
         cnt4_r <= 4'h0;
         cnt8_r <= 8'h00;
      end else if (soft_rst) begin
         div2_r <= 1'b0;
         cnt4_r <= 4'h0;
         cnt8_r <= 8'h00;
      end else begin
         if (count_en)
            div2_r <= ~div2_r;
         if (cnt4_step)
            cnt4_r <= cnt4_r + 4'h1;
         // A correction write wins over a count step in the same cycle
         if (adj_inc)
            cnt8_r <= cnt8_r + 8'h01;
         else if (adj_dec)
            cnt8_r <= cnt8_r - 8'h01;
         else if (cnt8_step && !wr_adj)
            cnt8_r <= cnt8_r + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Time counters
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sec_r <= 8'h00;
         min_r <= 8'h00;
         hr_r <= 8'h00;
         wk_r <= 3'h0;
         ctrl2_r <= 5'h00;
      end else if (soft_rst) begin
         sec_r <= 8'h00;
         min_r <= 8'h00;
         hr_r <= 8'h00;
         wk_r <= 3'h0;
         ctrl2_r <= 5'h00;
      end else begin
         if (wr_sec)
            sec_r <= wdata_i & `SEC_MASK;
         else if (sec_tick)
            sec_r <= sec_w[7:0];
         if (wr_min)
            min_r <= wdata_i & `MIN_MASK;
         else if (min_upd)
            min_r <= min_w[7:0];
         if (wr_hr)
            hr_r <= wdata_i & `HR_MASK;
         else if (hr_upd)
            hr_r <= hr_w[7:0];
         if (wr_wk)
            wk_r <= wdata_i[2:0];
         else if (day_upd)
            wk_r <= wk_next;
         if (wr_c2)
            ctrl2_r <= wdata_i[4:0] & 5'(`C2_MASK);
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
         timer_output_pin_o <= 1'b0;
         timer_output_oe_o <= 1'b0;
         periodic_irq_o <= 1'b0;
      end else begin
         rdata_o <= re_i ? rd_mux : 8'h00;
         timer_output_pin_o <= pin_nxt;
         timer_output_oe_o <= ctrl1_r.clock_out_enable;
         periodic_irq_o <= irq_nxt && !soft_rst;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   status_follow_a: assert property ($rose(ctrl1_r.count_status_flag) |-> $past(ctrl1_r.run_control))
      else $error("count status rose without run");
   run_start_a: assert property (wr_c1 && c1_wr.run_control && !soft_rst |=> ctrl1_r.run_control)
      else $error("run bit not taken");
   pin_gate_a: assert property (!ctrl1_r.clock_out_enable |=> !timer_output_pin_o && !timer_output_oe_o)
      else $error("clock driven while output disabled");
   soft_time_a: assert property (soft_rst |=> sec_r == 8'h00 && min_r == 8'h00 && hr_r == 8'h00
                                 && wk_r == 3'h0 && ctrl2_r == 5'h00)
      else $error("time not cleared by soft reset");
   soft_ctrl_a: assert property (soft_rst |=> !ctrl1_r.run_control && !ctrl1_r.count_status_flag
                                 && !ctrl1_r.meridiem_flag && !ctrl1_r.hour_format_select
                                 && !ctrl1_r.irq_timing)
      else $error("control not cleared by soft reset");
   soft_pre_a: assert property (soft_rst |=> cnt8_r == 8'h00 && cnt4_r == 4'h0)
      else $error("prescalers not cleared");
   hour12_a: assert property (hr_upd && !ctrl1_r.hour_format_select && hr_r == `HR12_MAX
                              |=> hr_r == 8'h00 && ctrl1_r.meridiem_flag != $past(ctrl1_r.meridiem_flag))
      else $error("12-hour wrap wrong");
   week_irq_a: assert property (week_evt && ctrl2_r[`IE_WEEK] |=> periodic_irq_o && wk_r == 3'h0)
      else $error("weekly request missing");
   sec_irq_a: assert property (sec_tick && ctrl2_r[`IE_SEC] |=> periodic_irq_o)
      else $error("second request missing");
   adj_none_a: assert property (wr_adj && (wdata_i[1:0] == 2'h0 || wdata_i[1:0] == 2'h3)
                                |=> $stable(cnt8_r))
      else $error("prescaler moved on null correction");
   wr_block_a: assert property (we_i && !time_wr_ok && addr_i == ADDR_W'(`OFF_SECONDS) && !sec_tick
                                |=> $stable(sec_r))
      else $error("time written while running");
   sec_wrap_a: assert property (sec_tick && sec_r == `SEC_MAX |=> sec_r == 8'h00 ##0 $past(min_upd))
      else $error("seconds wrap wrong");
endmodule

//--- shared/rtc_params.svh
// Purpose: Named offsets, field positions, reset values and counts for the calendar timer.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define RTC_ADDR_W 12
`define OFF_SECONDS 12'h118
`define OFF_MINUTES 12'h119
`define OFF_HOURS 12'h11a
`define OFF_WEEKDAY 12'h11b
`define OFF_CTRL1 12'h11c
`define OFF_CTRL2 12'h11d
`define OFF_CSRC 12'h11e
`define OFF_ADJUST 12'h11f

`define C1_SRST 4
`define C1_RESET 8'h00
`define C1_RD_MASK 8'hfe
`define CSRC_RESET 8'h08
`define CSRC_MASK 8'h7f
`define C2_MASK 8'h1f
`define ADJ_DEC 0
`define ADJ_INC 1
`define IE_WEEK 0
`define IE_DAY 1
`define IE_HOUR 2
`define IE_MIN 3
`define IE_SEC 4

`define SEC_MASK 8'h7f
`define MIN_MASK 8'h7f
`define HR_MASK 8'h3f
`define SEC_MAX 8'h59
`define MIN_MAX 8'h59
`define HR24_MAX 8'h23
`define HR12_MAX 8'h11
`define WK_MAX 3'h6
`define SLOW_EDGE_TOP 3'h7
`define CNT4_TOP 4'hf
`define CNT8_TOP 8'hff
`define HZ_BIT 7

`endif

//--- shared/rtc_pkg.sv
// Purpose: Types shared by the calendar timer files.
// Assumes: Nothing imported; users write rtc_pkg::name.
// Notes:   Control layout is msb first.
package rtc_pkg;

   typedef enum logic [2:0] {
      OSEL_F2 = 3'h0,
      OSEL_FC = 3'h1,
      OSEL_F4 = 3'h2,
      OSEL_1HZ = 3'h3,
      OSEL_F8 = 3'h4
   } out_sel_e;

   typedef struct packed {
      logic run_control;
      logic hour_format_select;
      logic meridiem_flag;
      logic soft_timer_reset;
      logic irq_timing;
      logic clock_out_enable;
      logic count_status_flag;
      logic unused_b0;
   } ctrl1_s;

   typedef struct packed {
      logic f2;
      logic fc;
      logic f4;
      logic f8;
   } clk_taps_s;

endpackage

//--- logic/rtc_divider.sv
// Purpose: Square-wave taps of the system clock and the sub-clock, and the count source enable.
// Assumes: subclk_edge_i pulses once per edge of the sub-clock, synchronous to clk_i.
// Notes:   Not touched by the soft timer reset.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_divider (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic subclk_edge_i,
   output rtc_pkg::clk_taps_s taps_o,
   output logic slow_en_o
);
   logic [2:0] sys_cnt_r;
   logic [2:0] edge_cnt_r;
   logic fc_r;

   assign taps_o.f2 = sys_cnt_r[0];
   assign taps_o.f4 = sys_cnt_r[1];
   assign taps_o.f8 = sys_cnt_r[2];
   assign taps_o.fc = fc_r;

   // Eight sub-clock edges make one count source period
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sys_cnt_r <= 3'h0;
         edge_cnt_r <= 3'h0;
         fc_r <= 1'b0;
         slow_en_o <= 1'b0;
      end else begin
         sys_cnt_r <= sys_cnt_r + 3'h1;
         slow_en_o <= subclk_edge_i && (edge_cnt_r == `SLOW_EDGE_TOP);
         if (subclk_edge_i) begin
            fc_r <= ~fc_r;
            edge_cnt_r <= edge_cnt_r + 3'h1;
         end
      end
   end
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the calendar timer through its register port and pins.
// Assumes: Sub-clock edge held high, so one count enable every 8 clocks and 65536 clocks per second.
// Notes:   Seconds come fast by stepping the stopped 8-bit prescaler to its top with corrections.
`timescale 1ns/1ps
`include "rtc_params.svh"
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic subclk_edge_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0] wdata_i = 8'h00;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic [7:0] rdata_o;
   logic timer_output_pin_o;
   logic timer_output_oe_o;
   logic periodic_irq_o;
   int bad_count = 0;
   int cmp_count = 0;
   int wait_n;
   logic [7:0] v;
   int toggles [5] = '{32, 32, 16, 0, 8};

   always #10 clk_i = ~clk_i;

   rtc_calendar #(.ADDR_W(`RTC_ADDR_W)) uut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .subclk_edge_i(subclk_edge_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .we_i(we_i),
      .re_i(re_i),
      .rdata_o(rdata_o),
      .timer_output_pin_o(timer_output_pin_o),
      .timer_output_oe_o(timer_output_oe_o),
      .periodic_irq_o(periodic_irq_o)
   );

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
      rd(a);
      chk(name, v, exp);
   endtask

   task automatic set_time(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s, input logic [7:0] w);
      wr(`OFF_HOURS, h);
      wr(`OFF_MINUTES, m);
      wr(`OFF_SECONDS, s);
      wr(`OFF_WEEKDAY, w);
   endtask

   task automatic soft_reset();
      wr(`OFF_CTRL1, 8'h18);
      wr(`OFF_CTRL1, 8'h08);
   endtask

   // Steps the stopped 8-bit prescaler from 00h to ffh; the last four writes must net zero
   task automatic preload();
      repeat (255) wr(`OFF_ADJUST, 8'h02);
      wr(`OFF_ADJUST, 8'h01);
      wr(`OFF_ADJUST, 8'h02);
      wr(`OFF_ADJUST, 8'h03);
      wr(`OFF_ADJUST, 8'h00);
   endtask

   // Bounded wait for the request pulse; wait_n keeps the cycle count
   task automatic wait_irq(input string name);
      wait_n = 0;
      while (periodic_irq_o !== 1'b1 && wait_n < 1000) begin
         @(posedge clk_i);
         #1;
         wait_n++;
      end
      chk(name, {7'h00, periodic_irq_o}, 8'h01);
   endtask

   // Select changes only with the output disabled, then count pin edges over 32 cycles
   task automatic clock_out(input logic [2:0] code, input int exp_t);
      int t;
      logic prev;
      wr(`OFF_CTRL1, 8'h08);
      wr(`OFF_CSRC, {1'b0, code, 4'h8});
      wr(`OFF_CTRL1, 8'h0c);
      repeat (3) @(posedge clk_i);
      #1;
      chk("output enable", {7'h00, timer_output_oe_o}, 8'h01);
      t = 0;
      prev = timer_output_pin_o;
      repeat (32) begin
         @(posedge clk_i);
         #1;
         if (timer_output_pin_o !== prev) t++;
         prev = timer_output_pin_o;
      end
      chk("pin toggles", t[7:0], exp_t[7:0]);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   // The tests take a few thousand cycles; an uncorrected second alone would need 65536
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      $display("CHECK FAILED watchdog expected 1 seen 0");
      conclude();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      subclk_edge_i <= 1'b1;
      rdchk("control reset", `OFF_CTRL1, 8'h00);
      rdchk("source reset", `OFF_CSRC, 8'h08);
      rdchk("unmapped read", 12'h100, 8'h00);
      $display("test reset values done");

      wr(`OFF_CSRC, 8'h88);
      rdchk("source loose bit", `OFF_CSRC, 8'h08);
      wr(`OFF_CSRC, 8'h08);
      wr(`OFF_CTRL1, 8'h4b);
      rdchk("control loose bits", `OFF_CTRL1, 8'h48);
      wr(`OFF_CTRL1, 8'h08);
      $display("test loose bits done");

      wr(`OFF_SECONDS, 8'h58);
      rdchk("seconds load", `OFF_SECONDS, 8'h58);
      wr(`OFF_CTRL1, 8'h88);
      repeat (20) @(posedge clk_i);
      rdchk("status running", `OFF_CTRL1, 8'h8a);
      wr(`OFF_SECONDS, 8'h30);
      rdchk("locked seconds", `OFF_SECONDS, 8'h58);
      wr(`OFF_CTRL1, 8'h08);
      repeat (20) @(posedge clk_i);
      rdchk("status stopped", `OFF_CTRL1, 8'h08);
      wr(`OFF_SECONDS, 8'h30);
      rdchk("unlocked seconds", `OFF_SECONDS, 8'h30);
      $display("test run and lock done");

      soft_reset();
      wr(`OFF_CTRL2, 8'h03);
      set_time(8'h11, 8'h59, 8'h59, 8'h06);
      preload();
      wr(`OFF_CTRL1, 8'h28);
      wr(`OFF_CTRL1, 8'ha8);
      wait_irq("weekly request");
      chk("weekly delay", {7'h00, wait_n >= 257 && wait_n <= 264}, 8'h01);
      rdchk("seconds wrap", `OFF_SECONDS, 8'h00);
      rdchk("minutes wrap", `OFF_MINUTES, 8'h00);
      rdchk("hours 12h wrap", `OFF_HOURS, 8'h00);
      rdchk("weekday wrap", `OFF_WEEKDAY, 8'h00);
      rdchk("meridiem morning", `OFF_CTRL1, 8'h8a);
      wr(`OFF_CTRL1, 8'h08);
      $display("test 12-hour rollover done");

      soft_reset();
      wr(`OFF_CTRL2, 8'h1e);
      set_time(8'h11, 8'h59, 8'h59, 8'h03);
      preload();
      wr(`OFF_CTRL1, 8'h48);
      wr(`OFF_CTRL1, 8'hc8);
      wait_irq("hourly request");
      chk("second period", {7'h00, wait_n >= 257 && wait_n <= 264}, 8'h01);
      rdchk("hours 24h", `OFF_HOURS, 8'h12);
      rdchk("weekday kept", `OFF_WEEKDAY, 8'h03);
      rdchk("control two kept", `OFF_CTRL2, 8'h1e);
      rd(`OFF_CTRL1);
      chk("control 24h", v & 8'hdf, 8'hca);
      $display("test 24-hour count done");

      wr(`OFF_CTRL1, 8'h58);
      rdchk("reset pending", `OFF_HOURS, 8'h12);
      wr(`OFF_CTRL1, 8'h08);
      rdchk("reset hours", `OFF_HOURS, 8'h00);
      rdchk("reset weekday", `OFF_WEEKDAY, 8'h00);
      rdchk("reset control two", `OFF_CTRL2, 8'h00);
      rdchk("reset control one", `OFF_CTRL1, 8'h00);
      $display("test soft reset done");

      for (int i = 0; i < 5; i++) begin
         clock_out(i[2:0], toggles[i]);
      end
      clock_out(3'h3, 0);
      wr(`OFF_ADJUST, 8'h01);
      @(posedge clk_i);
      #1;
      chk("one hertz level", {7'h00, timer_output_pin_o}, 8'h01);
      wr(`OFF_CTRL1, 8'h08);
      repeat (3) @(posedge clk_i);
      #1;
      chk("output off", {6'h00, timer_output_oe_o, timer_output_pin_o}, 8'h00);
      $display("test clock output done");
      conclude();
   end
endmodule
